// ---- pif_pkg.sv ----
/*
 * Constants for the PCI-side interrupt flag block: APB offsets, flag bit
 * positions, field layouts and reset values.
 * Assumes a 32-bit APB with word-aligned registers.
 */
`default_nettype none

package pif_pkg;
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned FLAG_W          = 64;

    // word-aligned byte offsets
    localparam logic [ADDR_W-1:0] OFF_SUM_LO = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_SUM_HI = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_ENB_LO = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_ENB_HI = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_OUTCFG = 12'h010;

    // interrupt summary bit positions
    localparam int unsigned BIT_CORE_DMA    = 41;
    localparam int unsigned BIT_PCI_WPERR   = 40;
    localparam int unsigned BIT_PAIR_TOUT   = 31;
    localparam int unsigned BIT_PAIR_PERR   = 27;
    localparam int unsigned BIT_GATHER_TOUT = 23;
    localparam int unsigned BIT_PKT_PERR    = 19;
    localparam int unsigned BIT_PKT_TOUT    = 15;
    localparam int unsigned BIT_DB_OVF      = 11;
    localparam int unsigned BIT_INSTR_TOUT  = 7;
    localparam int unsigned BIT_TOO_SMALL   = 3;
    localparam int unsigned BIT_SEC_PCI     = 2;
    localparam int unsigned BIT_RB_WTOUT    = 1;
    localparam int unsigned BIT_RB_RTOUT    = 0;

    // enable register implements bits 61..0, 63..62 read as zero
    localparam logic [FLAG_W-1:0] ENB_MASK  = 64'h3FFF_FFFF_FFFF_FFFF;
    localparam logic [FLAG_W-1:0] ENB_RESET = 64'h0000_0000_0000_0000;
    localparam logic [FLAG_W-1:0] SUM_RESET = 64'h0000_0000_0000_0000;

    // output configuration: info pointer byte count field
    localparam int unsigned       INFO_POINTER_BYTES_LSB   = 16;
    localparam int unsigned       INFO_POINTER_BYTES_W     = 7;
    localparam logic [INFO_POINTER_BYTES_W-1:0] INFO_POINTER_BYTES_RESET = 7'h00;

    localparam int unsigned DMA_MAX_WORDS   = 128;
endpackage

`default_nettype wire

// ---- pif_interrupt_flags.sv ----
/*
 * Interrupt summary and enable logic of the PCI packet/instruction interface,
 * with an APB slave for the summary, enable and output-size configuration.
 * Assumes event inputs are single-cycle pulses synchronous to i_sys_clk and
 * that the secondary status/enable vectors come from registers elsewhere.
 */
// Chosen here: the register addresses and the APB interface to the registers.
`default_nettype none

// Behaviour
// - a gather-list read time-out on port 0 sets summary bit 23, reset 0, write 1 clears.
// - a packet-data parity error on port 0 sets sticky summary bit 19, write 1 clears.
// - a packet-data read time-out on port 0 sets summary bit 15, write 1 clears.
// - the doorbell count bit 31 becoming set sets summary bit 11, write 1 clears.
// - an instruction read time-out on port 0 sets summary bit 7, reset 0, write 1 clears.
// - a sent packet shorter than the info pointer byte size sets summary bit 3.
// - summary bit 2 is read-only and reads 1 when any secondary status and enable pair is set.
// - a register bus write with no commit back sets summary bit 1.
// - a register bus read with no data back sets summary bit 0.
// - the enable register holds read-write bits 61 to 0 reset to 0 that gate each flag.
// - summary bit 2 interrupts only when enable bit 2 is set.
// - a core DMA read request above 128 words sets summary bit 41.
// - a parity error on PCI data written to the cache sets summary bit 40.
// - an output pair read time-out on port 0 sets summary bit 31.
// - an output pair parity error on port 0 sets summary bit 27.
module pif_interrupt_flags #(
    parameter int unsigned PKT_LEN_W = 16,
    parameter int unsigned DMA_W     = 9,
    parameter int unsigned SEC_W     = 32
) (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_psel,
    input  wire logic                         i_penable,
    input  wire logic                         i_pwrite,
    input  wire logic [pif_pkg::ADDR_W-1:0]   i_paddr,
    input  wire logic [pif_pkg::DATA_W-1:0]   i_pwdata,
    input  wire logic [3:0]                   i_pstrb,
    output logic                              o_pready,
    output logic [pif_pkg::DATA_W-1:0]        o_prdata,
    output logic                              o_pslverr,
    input  wire logic                         i_gather_read_timeout,
    input  wire logic                         i_packet_data_parity_err,
    input  wire logic                         i_packet_data_read_timeout,
    input  wire logic                         i_doorbell_count_msb,
    input  wire logic                         i_instr_read_timeout,
    input  wire logic                         i_out_pkt_sent,
    input  wire logic [PKT_LEN_W-1:0]         i_out_pkt_bytes,
    input  wire logic [SEC_W-1:0]             i_secondary_pci_status,
    input  wire logic [SEC_W-1:0]             i_secondary_pci_enable,
    input  wire logic                         i_regbus_write_timeout,
    input  wire logic                         i_regbus_read_timeout,
    input  wire logic                         i_core_dma_req,
    input  wire logic [DMA_W-1:0]             i_core_dma_words,
    input  wire logic                         i_pci_write_parity_err,
    input  wire logic                         i_output_pair_read_timeout,
    input  wire logic                         i_output_pair_parity_err,
    output logic                              o_irq
);
    import pif_pkg::*;

    // length must hold the info size, dma count must hold the limit
    if (PKT_LEN_W < INFO_POINTER_BYTES_W || DMA_W < 8 || DMA_W > 31 || SEC_W < 1) begin : g_bad_param
        $error("pif_interrupt_flags: unsupported parameter values");
    end

    function automatic logic [FLAG_W-1:0] lane_mask(input logic hi, input logic [3:0] strb);
        logic [DATA_W-1:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        lane_mask = hi ? {m, 32'h0000_0000} : {32'h0000_0000, m};
    endfunction

    localparam logic [FLAG_W-1:0] STICKY_MASK =
        (64'h1 << BIT_CORE_DMA)   | (64'h1 << BIT_PCI_WPERR) | (64'h1 << BIT_PAIR_TOUT) |
        (64'h1 << BIT_PAIR_PERR)  | (64'h1 << BIT_GATHER_TOUT) | (64'h1 << BIT_PKT_PERR) |
        (64'h1 << BIT_PKT_TOUT)   | (64'h1 << BIT_DB_OVF)    | (64'h1 << BIT_INSTR_TOUT) |
        (64'h1 << BIT_TOO_SMALL)  | (64'h1 << BIT_RB_WTOUT)  | (64'h1 << BIT_RB_RTOUT);
    localparam logic [DMA_W-1:0]     DMA_LIMIT = DMA_W'(DMA_MAX_WORDS);

    logic [FLAG_W-1:0]  sum_q, sum_d;
    logic [FLAG_W-1:0]  enb_q, enb_d;
    logic [INFO_POINTER_BYTES_W-1:0] info_pointer_bytes_q, info_pointer_bytes_d;
    logic               db_msb_q, db_msb_d;
    logic [DATA_W-1:0]  rdata_q, rdata_d;
    logic [FLAG_W-1:0]  set_vec, clr_vec, sum_rd;
    logic               sec_live;
    logic               wr_acc, setup, hit;

    assign setup    = i_psel && !i_penable;
    assign wr_acc   = i_psel && i_penable && i_pwrite;
    assign hit      = (i_paddr == OFF_SUM_LO) || (i_paddr == OFF_SUM_HI) ||
                      (i_paddr == OFF_ENB_LO) || (i_paddr == OFF_ENB_HI) ||
                      (i_paddr == OFF_OUTCFG);
    // zero wait states: read data was captured in the setup cycle
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;
    assign o_prdata  = rdata_q;

    // live summary of the secondary group, never stored
    assign sec_live = |(i_secondary_pci_status & i_secondary_pci_enable);

    always_comb begin
        sum_rd = sum_q;
        sum_rd[BIT_SEC_PCI] = sec_live;
    end

    assign o_irq = |(sum_rd & enb_q);

    always_comb begin
        set_vec = '0;
        set_vec[BIT_GATHER_TOUT] = i_gather_read_timeout;
        set_vec[BIT_PKT_PERR]    = i_packet_data_parity_err;
        set_vec[BIT_PKT_TOUT]    = i_packet_data_read_timeout;
        set_vec[BIT_DB_OVF]      = i_doorbell_count_msb && !db_msb_q;
        set_vec[BIT_INSTR_TOUT]  = i_instr_read_timeout;
        set_vec[BIT_TOO_SMALL]   = i_out_pkt_sent &&
            (i_out_pkt_bytes < PKT_LEN_W'(info_pointer_bytes_q));
        set_vec[BIT_RB_WTOUT]    = i_regbus_write_timeout;
        set_vec[BIT_RB_RTOUT]    = i_regbus_read_timeout;
        set_vec[BIT_CORE_DMA]    = i_core_dma_req && (i_core_dma_words > DMA_LIMIT);
        set_vec[BIT_PCI_WPERR]   = i_pci_write_parity_err;
        set_vec[BIT_PAIR_TOUT]   = i_output_pair_read_timeout;
        set_vec[BIT_PAIR_PERR]   = i_output_pair_parity_err;
        clr_vec = '0;
        if (wr_acc && (i_paddr == OFF_SUM_LO || i_paddr == OFF_SUM_HI)) begin
            clr_vec = lane_mask(i_paddr == OFF_SUM_HI, i_pstrb) &
                      ((i_paddr == OFF_SUM_HI) ? {i_pwdata, 32'h0000_0000}
                                               : {32'h0000_0000, i_pwdata});
        end
        // set beats clear so an event in the clearing cycle survives
        sum_d    = ((sum_q & ~clr_vec) | set_vec) & STICKY_MASK;
        db_msb_d = i_doorbell_count_msb;
    end

    always_comb begin
        enb_d   = enb_q;
        info_pointer_bytes_d = info_pointer_bytes_q;
        if (wr_acc && (i_paddr == OFF_ENB_LO || i_paddr == OFF_ENB_HI)) begin
            enb_d = ((enb_q & ~lane_mask(i_paddr == OFF_ENB_HI, i_pstrb)) |
                     (lane_mask(i_paddr == OFF_ENB_HI, i_pstrb) & {i_pwdata, i_pwdata}))
                    & ENB_MASK;
        end
        if (wr_acc && i_paddr == OFF_OUTCFG && i_pstrb[INFO_POINTER_BYTES_LSB/8]) begin
            info_pointer_bytes_d = i_pwdata[INFO_POINTER_BYTES_LSB +: INFO_POINTER_BYTES_W];
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (setup && !i_pwrite) begin
            unique case (i_paddr)
                OFF_SUM_LO: rdata_d = sum_rd[DATA_W-1:0];
                OFF_SUM_HI: rdata_d = sum_rd[FLAG_W-1:DATA_W];
                OFF_ENB_LO: rdata_d = enb_q[DATA_W-1:0];
                OFF_ENB_HI: rdata_d = enb_q[FLAG_W-1:DATA_W];
                OFF_OUTCFG: rdata_d = DATA_W'({info_pointer_bytes_q, 16'h0000});
                default:    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sum_q    <= SUM_RESET;
            enb_q    <= ENB_RESET;
            info_pointer_bytes_q  <= INFO_POINTER_BYTES_RESET;
            db_msb_q <= 1'b0;
            rdata_q  <= '0;
        end else begin
            sum_q    <= sum_d;
            enb_q    <= enb_d;
            info_pointer_bytes_q  <= info_pointer_bytes_d;
            db_msb_q <= db_msb_d;
            rdata_q  <= rdata_d;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    AST_GATHER: assert property (i_gather_read_timeout |=> sum_q[BIT_GATHER_TOUT])
        else $error("gather time-out flag not set");
    AST_PKT_PERR: assert property (i_packet_data_parity_err |=>
        sum_q[BIT_PKT_PERR])
        else $error("packet parity flag not set");
    AST_PKT_TOUT: assert property (i_packet_data_read_timeout |=> sum_q[BIT_PKT_TOUT])
        else $error("packet read time-out flag not set");
    AST_DB_OVF: assert property (!i_doorbell_count_msb ##1 i_doorbell_count_msb
        |=> sum_q[BIT_DB_OVF])
        else $error("doorbell overflow flag not set on rising msb");
    AST_INSTR: assert property (i_instr_read_timeout |=> sum_q[BIT_INSTR_TOUT])
        else $error("instruction time-out flag not set");
    AST_TOO_SMALL: assert property ($rose(sum_q[BIT_TOO_SMALL]) |->
        $past(i_out_pkt_sent) && $past(i_out_pkt_bytes) < PKT_LEN_W'($past(info_pointer_bytes_q)))
        else $error("too-small flag set without a short packet");
    AST_SEC_RO: assert property (sum_rd[BIT_SEC_PCI] == sec_live && !sum_q[BIT_SEC_PCI])
        else $error("secondary summary bit is not a live read-only value");
    AST_RB_WT: assert property (i_regbus_write_timeout |=> sum_q[BIT_RB_WTOUT])
        else $error("register bus write time-out flag not set");
    AST_RB_RT: assert property (i_regbus_read_timeout |=> sum_q[BIT_RB_RTOUT])
        else $error("register bus read time-out flag not set");
    AST_ENB_RAZ: assert property (enb_q[FLAG_W-1:FLAG_W-2] == 2'b00)
        else $error("enable register reserved bits not zero");
    AST_ENB_WR: assert property (wr_acc && i_paddr == OFF_ENB_LO && i_pstrb == 4'hF |=>
        enb_q[DATA_W-1:0] == $past(i_pwdata))
        else $error("enable register low word write lost");
    AST_SEC_GATE: assert property (sec_live && !enb_q[BIT_SEC_PCI] &&
        ((sum_q & enb_q) == 64'h0) |-> !o_irq)
        else $error("secondary summary interrupts while disabled");
    AST_DMA: assert property (i_core_dma_req && i_core_dma_words > DMA_LIMIT
        |=> sum_q[BIT_CORE_DMA])
        else $error("core DMA size flag not set");
    AST_DMA_EDGE: assert property ($rose(sum_q[BIT_CORE_DMA]) |->
        $past(i_core_dma_words) > DMA_LIMIT)
        else $error("core DMA flag set at or below the limit");
    AST_WPERR: assert property (i_pci_write_parity_err |=> sum_q[BIT_PCI_WPERR])
        else $error("PCI write parity flag not set");
    AST_PAIR_T: assert property (i_output_pair_read_timeout |=> sum_q[BIT_PAIR_TOUT])
        else $error("output pair time-out flag not set");
    AST_PAIR_P: assert property (i_output_pair_parity_err |=> sum_q[BIT_PAIR_PERR])
        else $error("output pair parity flag not set");
    AST_IRQ: assert property (o_irq == |(sum_rd & enb_q))
        else $error("interrupt output does not follow flags and enables");
    AST_IRQ_ON: assert property (sum_q[BIT_PKT_TOUT] && enb_q[BIT_PKT_TOUT] |-> o_irq)
        else $error("enabled flag does not interrupt");
    AST_W0_KEEP: assert property (sum_q[BIT_GATHER_TOUT] && wr_acc &&
        i_paddr == OFF_SUM_LO && !i_pwdata[BIT_GATHER_TOUT] |=> sum_q[BIT_GATHER_TOUT])
        else $error("writing zero changed a flag");
    AST_W1_CLR: assert property (wr_acc && i_paddr == OFF_SUM_LO && i_pstrb == 4'hF &&
        i_pwdata[BIT_RB_RTOUT] && !i_regbus_read_timeout |=> !sum_q[BIT_RB_RTOUT])
        else $error("write one did not clear the flag");

    // set must win over a clear landing in the same cycle
    AST_SET_WINS: assert property (wr_acc && i_paddr == OFF_SUM_LO && i_pstrb[0] &&
        i_pwdata[BIT_INSTR_TOUT] && i_instr_read_timeout |=> sum_q[BIT_INSTR_TOUT])
        else $error("event lost against a clear");
    AST_W1C_HI: assert property (wr_acc && i_paddr == OFF_SUM_HI && i_pstrb[1] &&
        i_pwdata[BIT_PCI_WPERR-DATA_W] && !i_pci_write_parity_err |=> !sum_q[BIT_PCI_WPERR])
        else $error("high word write one did not clear the flag");
    AST_SPARE_ZERO: assert property ((sum_q & ~STICKY_MASK) == '0)
        else $error("spare summary bit became set");
    AST_DB_LEVEL: assert property (i_doorbell_count_msb && db_msb_q &&
        !sum_q[BIT_DB_OVF] |=> !sum_q[BIT_DB_OVF])
        else $error("doorbell flag set by a steady level");

    // strict compares: the boundary values must not set a flag
    AST_SMALL_SET: assert property (i_out_pkt_sent &&
        i_out_pkt_bytes < PKT_LEN_W'(info_pointer_bytes_q) |=> sum_q[BIT_TOO_SMALL])
        else $error("too-small flag not set");
    AST_SMALL_EQ: assert property (i_out_pkt_sent &&
        i_out_pkt_bytes == PKT_LEN_W'(info_pointer_bytes_q) && !sum_q[BIT_TOO_SMALL] |=> !sum_q[BIT_TOO_SMALL])
        else $error("too-small flag set at the info size");
    AST_DMA_LIMIT: assert property (i_core_dma_req && i_core_dma_words == DMA_LIMIT &&
        !sum_q[BIT_CORE_DMA] |=> !sum_q[BIT_CORE_DMA])
        else $error("core DMA flag set at the limit");

    AST_ENB_HI_WR: assert property (wr_acc && i_paddr == OFF_ENB_HI && i_pstrb == 4'hF |=>
        enb_q[FLAG_W-1:DATA_W] == ($past(i_pwdata) & ENB_MASK[FLAG_W-1:DATA_W]))
        else $error("enable register high word write wrong");
    AST_ENB_KEEP: assert property (!wr_acc |=> $stable(enb_q))
        else $error("enable register changed without a write");
    AST_ENB_RD: assert property (setup && !i_pwrite && i_paddr == OFF_ENB_LO |=>
        o_prdata == $past(enb_q[DATA_W-1:0]))
        else $error("enable register read data wrong");
    AST_ERR_MAPPED: assert property (i_psel && i_penable && i_paddr == OFF_ENB_LO |->
        !o_pslverr)
        else $error("error response on a mapped register");
    AST_SUM_RD: assert property (setup && !i_pwrite && i_paddr == OFF_SUM_LO |=>
        o_prdata == $past(sum_rd[DATA_W-1:0]))
        else $error("summary read data wrong");

    // flags only move on an event or a clearing write
    AST_HOLD: assert property (!wr_acc && set_vec == '0 |=> sum_q == $past(sum_q))
        else $error("summary changed with no event and no write");
    AST_PERR_STICKY: assert property (sum_q[BIT_PKT_PERR] && !wr_acc |=>
        sum_q[BIT_PKT_PERR])
        else $error("packet parity flag dropped without a clear");
    AST_SEC_IRQ: assert property (sec_live && enb_q[BIT_SEC_PCI] |-> o_irq)
        else $error("enabled secondary summary does not interrupt");
    AST_PREADY: assert property (o_pready)
        else $error("ready dropped");

    COV_CLEAR: cover property (sum_q[BIT_PKT_PERR] ##1 wr_acc && i_paddr == OFF_SUM_LO
        ##1 !sum_q[BIT_PKT_PERR]);
    COV_SET_WINS: cover property (wr_acc && i_paddr == OFF_SUM_LO &&
        i_pwdata[BIT_INSTR_TOUT] && i_instr_read_timeout);
    COV_IRQ: cover property (!o_irq ##1 o_irq);
    COV_SEC: cover property (sec_live && enb_q[BIT_SEC_PCI] && o_irq);
    COV_SMALL: cover property (i_out_pkt_sent && i_out_pkt_bytes < PKT_LEN_W'(info_pointer_bytes_q)
        ##1 sum_q[BIT_TOO_SMALL]);
endmodule

`default_nettype wire

// ---- pif_interrupt_flags_tb_top.sv ----
/*
 * Self-checking bench for the interrupt flag block: APB register access,
 * every event flag, enable gating, secondary summary and an unmapped address.
 * Assumes the APB slave answers with no wait states but waits for pready anyway.
 */
`default_nettype none

module pif_interrupt_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pif_pkg::*;

    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, db, sent, dreq, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, sst, sen;
    logic [15:0] bytes;
    logic [8:0]  ev, words;
    logic [6:0]  isz;
    logic [63:0] v;
    int          fails, checks_done, seed;
    // event bit order matches ev[0..8], then doorbell, too small, dma size
    localparam int BP [12] = '{BIT_GATHER_TOUT, BIT_PKT_PERR, BIT_PKT_TOUT, BIT_INSTR_TOUT,
        BIT_RB_WTOUT, BIT_RB_RTOUT, BIT_PCI_WPERR, BIT_PAIR_TOUT, BIT_PAIR_PERR,
        BIT_DB_OVF, BIT_TOO_SMALL, BIT_CORE_DMA};

    pif_interrupt_flags u_pif_interrupt_flags (
        .i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_gather_read_timeout(ev[0]),
        .i_packet_data_parity_err(ev[1]), .i_packet_data_read_timeout(ev[2]),
        .i_doorbell_count_msb(db), .i_instr_read_timeout(ev[3]), .i_out_pkt_sent(sent),
        .i_out_pkt_bytes(bytes), .i_secondary_pci_status(sst), .i_secondary_pci_enable(sen),
        .i_regbus_write_timeout(ev[4]), .i_regbus_read_timeout(ev[5]), .i_core_dma_req(dreq),
        .i_core_dma_words(words), .i_pci_write_parity_err(ev[6]),
        .i_output_pair_read_timeout(ev[7]), .i_output_pair_parity_err(ev[8]), .o_irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // setup, access until pready, release, one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr64(input logic [11:0] a, input logic [63:0] d);
        apb(1'b1, a, d[31:0]);
        apb(1'b1, a + 12'h004, d[63:32]);
    endtask

    task automatic rd64(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
        v[31:0] = rd;
        apb(1'b0, a + 12'h004, 32'h0000_0000);
        v[63:32] = rd;
    endtask

    function automatic logic [63:0] one_hot(input int b);
        return 64'h1 << b;
    endfunction

    // value read back is compared as seen; helper keeps the call readable
    function automatic logic [63:0] rd_v_mask(input logic [63:0] seen);
        return seen;
    endfunction

    // boundary value first, offending value second
    task automatic trig(input int k);
        if (k < 9) begin
            ev[k] <= 1'b1;
        end else if (k == 9) begin
            db <= 1'b1;
        end else if (k == 10) begin
            sent <= 1'b1; bytes <= {9'h000, isz};
            @(posedge clk);
            bytes <= {9'h000, isz - 7'h01};
        end else begin
            dreq <= 1'b1; words <= 9'h080;
            @(posedge clk);
            words <= 9'h081;
        end
        @(posedge clk);
        ev <= '0; db <= 1'b0; sent <= 1'b0; dreq <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        seed = 33936;
        fails = 0; checks_done = 0;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        ev = '0; db = 1'b0; sent = 1'b0; dreq = 1'b0; bytes = '0; words = '0;
        sst = '0; sen = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd64(OFF_SUM_LO);
        chk("sum reset", v, SUM_RESET);
        rd64(OFF_ENB_LO);
        chk("enb reset", v, ENB_RESET);
        v = {$random(seed), $random(seed)};
        wr64(OFF_ENB_LO, v);
        rd64(OFF_ENB_LO);
        chk("enb rw", rd_v_mask(v), v & ENB_MASK);
        wr64(OFF_ENB_LO, 64'h0);
        isz = 7'(($random(seed) & 32'h3F) + 1);
        apb(1'b1, OFF_OUTCFG, {9'h000, isz, 16'h0000});
        apb(1'b0, OFF_OUTCFG, 32'h0000_0000);
        chk("info size", rd[22:16], isz);
        for (int k = 0; k < 12; k++) begin
            trig(k);
            rd64(OFF_SUM_LO);
            chk("flag set", v, one_hot(BP[k]));
            chk("irq masked", irq, 1'b0);
            wr64(OFF_ENB_LO, one_hot(BP[k]));
            chk("irq on", irq, 1'b1);
            wr64(OFF_SUM_LO, ~one_hot(BP[k]));
            rd64(OFF_SUM_LO);
            chk("write zero", v, one_hot(BP[k]));
            wr64(OFF_SUM_LO, one_hot(BP[k]));
            rd64(OFF_SUM_LO);
            chk("w1c", v, 64'h0);
            chk("irq off", irq, 1'b0);
            wr64(OFF_ENB_LO, 64'h0);
        end
        for (int i = 0; i < 2; i++) begin
            sst <= $random(seed);
            sen <= (i == 0) ? 32'hFFFF_FFFF : 32'h0000_0000;
            @(posedge clk);
            apb(1'b1, OFF_SUM_LO, 32'h0000_0004);
            apb(1'b0, OFF_SUM_LO, 32'h0000_0000);
            chk("sec bit", rd[2], |(sst & sen));
            chk("sec masked", irq, 1'b0);
            apb(1'b1, OFF_ENB_LO, 32'h0000_0004);
            chk("sec irq", irq, |(sst & sen));
            apb(1'b1, OFF_ENB_LO, 32'h0000_0000);
        end
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk("unmapped data", rd, 32'h0000_0000);
        chk("unmapped err", slv, 1'b1);
        tally_and_finish();
    end
endmodule

`default_nettype wire
